//--- shared/sfp_pkg.sv
// Constants and types shared by the sector flash host controller.
package sfp_pkg;
	// Clock period and documented times in their own units.
	localparam int CLK_NS = 8;
	localparam int T_AS_NS = 10;
	localparam int T_WP_NS = 200;
	localparam int T_WPH_NS = 200;
	localparam int T_ACC_NS = 250;
	localparam int T_OEHP_NS = 150;
	localparam int BYTE_LOAD_WINDOW_US = 150;
	localparam int PROGRAM_CYCLE_TIME_MS = 20;

	// Least times, access time and program timeout round up; the load window rounds down.
	localparam int AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int OEHP_CYC = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOAD_WIN_CYC = (BYTE_LOAD_WINDOW_US * 1000) / CLK_NS;
	localparam int PROG_TMO_CYC =
		(PROGRAM_CYCLE_TIME_MS * 1000000 + CLK_NS - 1) / CLK_NS;

	// Geometry of the array and of a sector.
	localparam int ADDR_W = 17;
	localparam int SEQ_ADDR_W = 15;
	localparam logic [6:0] LAST_BYTE = 7'h7f;

	// Command sequence keys and command bytes; values are arbitrary.
	localparam logic [14:0] KEY_ADDR1 = 15'h1111;
	localparam logic [14:0] KEY_ADDR2 = 15'h2222;
	localparam logic [7:0] KEY_DAT1 = 8'ha5;
	localparam logic [7:0] KEY_DAT2 = 8'h5a;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h20;
	localparam logic [7:0] CMD_ID_EXIT = 8'h30;
	localparam logic [7:0] CMD_LOCK_LO = 8'h40;
	localparam logic [7:0] CMD_LOCK_HI = 8'h50;
	localparam logic [1:0] LAST_STEP = 2'h2;

	// Operations that the user side may request.
	typedef enum logic [2:0] {
		SFP_OP_READ = 3'b000,
		SFP_OP_PROG = 3'b001,
		SFP_OP_ID_ENTRY = 3'b010,
		SFP_OP_ID_EXIT = 3'b011,
		SFP_OP_LOCK_LO = 3'b100,
		SFP_OP_LOCK_HI = 3'b101
	} sfp_op_e;

	// Bus cycle states of the controller.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_WSET = 3'b010,
		ST_WLOW = 3'b011,
		ST_WHIGH = 3'b100,
		ST_RLOW = 3'b101,
		ST_RHIGH = 3'b110
	} sfp_state_e;
endpackage

//--- design/sfp_host.sv
// Host controller that reads, programs and commands a sector flash.
// Summary of operation
// - Each sector byte load carries the sector number on address bits 16..7.
// - Every program operation not abandoned on a load gap loads exactly 128 bytes.
// - Successive byte loads start within 150 us of each other.
// - Status polling toggles output and chip enable for each read.
// - First and last toggle bit values are not trusted on their own.
// - All status polls of one program use the same address.
`timescale 1ns/100ps
`default_nettype none
module sfp_host #(
	parameter int LOAD_WIN = sfp_pkg::LOAD_WIN_CYC,
	parameter int PROG_TMO = sfp_pkg::PROG_TMO_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sfp_pkg::sfp_op_e cmd_op,
	input wire logic [16:0] cmd_addr,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic done,
	output logic err,
	output logic busy,
	output logic [16:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic [7:0] flash_dq_i,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_n
);
	import sfp_pkg::*;

	// Waiting cycles allowed between loads once a write cycle is counted.
	localparam int GAP_INT = LOAD_WIN - AS_CYC - WP_CYC - WPH_CYC - 2;
	localparam logic [21:0] GAP_LIM = 22'(GAP_INT);
	localparam logic [21:0] TMO_LIM = 22'(PROG_TMO);
	localparam logic [7:0] AS_C = 8'(AS_CYC - 1);
	localparam logic [7:0] WP_C = 8'(WP_CYC - 1);
	localparam logic [7:0] WPH_C = 8'(WPH_CYC - 1);
	// The pins lag the state by one cycle, so one extra count is needed.
	localparam logic [7:0] ACC_C = 8'(ACC_CYC);
	localparam logic [7:0] OEHP_C = 8'(OEHP_CYC - 1);

	sfp_state_e state_ff;
	sfp_op_e op_ff;
	logic [7:0] cnt_ff;
	logic [21:0] tmo_ff;
	logic [1:0] step_ff;
	logic [6:0] bidx_ff;
	logic loading_ff;
	logic polls_ff;
	logic tog_ff;
	logic fin_ff;
	logic [9:0] sec_ff;
	logic [16:0] wa_ff;
	logic [7:0] wd_ff;
	logic [7:0] rd_data_ff;
	logic done_ff;
	logic err_ff;

	// Key address of a sequence step; bits above 14 stay low.
	function automatic logic [16:0] seq_addr(input logic [1:0] step);
		logic [14:0] a;
		a = (step == 2'h1) ? KEY_ADDR2 : KEY_ADDR1;
		return {2'b00, a};
	endfunction

	// Data byte of a sequence step; the last step names the command.
	function automatic logic [7:0] seq_data(input logic [1:0] step,
		input sfp_op_e op);
		logic [7:0] d;
		d = KEY_DAT1;
		if (step == 2'h1) begin
			d = KEY_DAT2;
		end else if (step == LAST_STEP) begin
			unique case (op)
				SFP_OP_PROG: d = CMD_PROG;
				SFP_OP_ID_ENTRY: d = CMD_ID_ENTRY;
				SFP_OP_ID_EXIT: d = CMD_ID_EXIT;
				SFP_OP_LOCK_LO: d = CMD_LOCK_LO;
				SFP_OP_LOCK_HI: d = CMD_LOCK_HI;
				default: d = KEY_DAT1;
			endcase
		end
		return d;
	endfunction

	// Handshakes are decoded from the state; wr_ready also needs wr_valid.
	assign cmd_ready = (state_ff == ST_IDLE);
	assign wr_ready = (state_ff == ST_WAIT) && wr_valid;
	assign busy = (state_ff != ST_IDLE);
	assign rd_data = rd_data_ff;
	assign done = done_ff;
	assign err = err_ff;

	// Sequencer: key writes, byte loads, status polls and plain reads.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			op_ff <= SFP_OP_READ;
			cnt_ff <= 8'h00;
			tmo_ff <= 22'h000000;
			step_ff <= 2'h0;
			bidx_ff <= 7'h00;
			loading_ff <= 1'b0;
			polls_ff <= 1'b0;
			tog_ff <= 1'b0;
			fin_ff <= 1'b0;
			sec_ff <= 10'h000;
			wa_ff <= 17'h00000;
			wd_ff <= 8'h00;
			rd_data_ff <= 8'h00;
			done_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			unique case (state_ff)
				ST_IDLE: begin
					if (cmd_valid) begin
						op_ff <= cmd_op;
						sec_ff <= cmd_addr[16:7];
						step_ff <= 2'h0;
						bidx_ff <= 7'h00;
						loading_ff <= 1'b0;
						err_ff <= 1'b0;
						if (cmd_op == SFP_OP_READ) begin
							// Identification codes are plain reads at 0 and 1.
							wa_ff <= cmd_addr;
							cnt_ff <= ACC_C;
							state_ff <= ST_RLOW;
						end else begin
							// Every command, program too, starts with keys.
							wa_ff <= seq_addr(2'h0);
							wd_ff <= seq_data(2'h0, cmd_op);
							cnt_ff <= AS_C;
							state_ff <= ST_WSET;
						end
					end
				end
				ST_WAIT: begin
					tmo_ff <= tmo_ff + 22'h000001;
					if (wr_valid) begin
						wa_ff <= {sec_ff, bidx_ff};
						wd_ff <= wr_data;
						cnt_ff <= AS_C;
						state_ff <= ST_WSET;
					end else if (tmo_ff >= GAP_LIM) begin
						// The window would lapse; abandon the sector.
						err_ff <= 1'b1;
						done_ff <= 1'b1;
						loading_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end
				end
				ST_WSET: begin
					cnt_ff <= cnt_ff - 8'h01;
					if (cnt_ff == 8'h00) begin
						cnt_ff <= WP_C;
						state_ff <= ST_WLOW;
					end
				end
				ST_WLOW: begin
					cnt_ff <= cnt_ff - 8'h01;
					if (cnt_ff == 8'h00) begin
						cnt_ff <= WPH_C;
						state_ff <= ST_WHIGH;
					end
				end
				ST_WHIGH: begin
					cnt_ff <= cnt_ff - 8'h01;
					if (cnt_ff == 8'h00) begin
						if (!loading_ff && step_ff != LAST_STEP) begin
							step_ff <= step_ff + 2'h1;
							wa_ff <= seq_addr(step_ff + 2'h1);
							wd_ff <= seq_data(step_ff + 2'h1, op_ff);
							cnt_ff <= AS_C;
							state_ff <= ST_WSET;
						end else if (op_ff != SFP_OP_PROG) begin
							done_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end else if (loading_ff && bidx_ff == LAST_BYTE) begin
							// All 128 bytes are in; poll the last address.
							polls_ff <= 1'b0;
							fin_ff <= 1'b0;
							tmo_ff <= 22'h000000;
							cnt_ff <= ACC_C;
							state_ff <= ST_RLOW;
						end else begin
							if (loading_ff) begin
								bidx_ff <= bidx_ff + 7'h01;
							end
							loading_ff <= 1'b1;
							tmo_ff <= 22'h000000;
							state_ff <= ST_WAIT;
						end
					end
				end
				ST_RLOW: begin
					cnt_ff <= cnt_ff - 8'h01;
					if (op_ff == SFP_OP_PROG) begin
						tmo_ff <= tmo_ff + 22'h000001;
					end
					if (cnt_ff == 8'h00) begin
						rd_data_ff <= flash_dq_i;
						tog_ff <= flash_dq_i[6];
						// Only a match of two reads counts as finished.
						fin_ff <= polls_ff && (flash_dq_i[6] == tog_ff);
						cnt_ff <= OEHP_C;
						state_ff <= ST_RHIGH;
					end
				end
				ST_RHIGH: begin
					cnt_ff <= cnt_ff - 8'h01;
					if (op_ff == SFP_OP_PROG) begin
						tmo_ff <= tmo_ff + 22'h000001;
					end
					if (cnt_ff == 8'h00) begin
						if (op_ff != SFP_OP_PROG || fin_ff) begin
							loading_ff <= 1'b0;
							done_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end else if (tmo_ff >= TMO_LIM) begin
							loading_ff <= 1'b0;
							err_ff <= 1'b1;
							done_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end else begin
							// Next status read at the same address.
							polls_ff <= 1'b1;
							cnt_ff <= ACC_C;
							state_ff <= ST_RLOW;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Pin drivers follow the state one cycle later, keeping every phase.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_addr <= 17'h00000;
			flash_dq_o <= 8'h00;
			flash_dq_oe_n <= 1'b1;
		end else begin
			flash_ce_n <= !(state_ff == ST_WLOW || state_ff == ST_RLOW);
			flash_we_n <= !(state_ff == ST_WLOW);
			flash_oe_n <= !(state_ff == ST_RLOW);
			flash_addr <= wa_ff;
			flash_dq_o <= wd_ff;
			flash_dq_oe_n <= !(state_ff == ST_WSET || state_ff == ST_WLOW ||
				state_ff == ST_WHIGH);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_oe_during_write: assert property (!flash_we_n |-> flash_oe_n)
		else $error("Output enable low during a write strobe.");
	a_sector_on_load: assert property ($fell(flash_we_n) && loading_ff
		|-> flash_addr[16:7] == sec_ff)
		else $error("Byte load without the sector address.");
	a_full_sector: assert property (state_ff == ST_RLOW &&
		$past(state_ff) == ST_WHIGH |-> bidx_ff == LAST_BYTE && loading_ff)
		else $error("Polling began before 128 bytes were loaded.");
	a_load_gap: assert property (state_ff == ST_WAIT |->
		tmo_ff <= GAP_LIM)
		else $error("Gap between byte loads too long.");
	a_poll_toggle: assert property (state_ff == ST_RHIGH && cnt_ff == 8'h00
		&& op_ff == SFP_OP_PROG && !fin_ff && tmo_ff < TMO_LIM
		|=> state_ff == ST_RLOW ##1 !flash_oe_n && !flash_ce_n)
		else $error("Status poll did not strobe a new read.");
	a_first_poll: assert property (state_ff == ST_RHIGH && !polls_ff
		|-> !fin_ff)
		else $error("Program finish taken from a single poll.");
	a_poll_addr: assert property (state_ff == ST_RHIGH &&
		op_ff == SFP_OP_PROG |=> $stable(flash_addr))
		else $error("Poll address changed between reads.");
	a_seq_upper: assert property (!flash_we_n && !loading_ff
		|-> flash_addr[16:15] == 2'b00)
		else $error("Command write with high address bits set.");
endmodule // sfp_host
`default_nettype wire

//--- sim/sfp_flash_model.sv
// Behavioural model of the sector flash at its pins.
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_model #(
	parameter int PROG_NS = 5000
) (
	input wire logic [16:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_n,
	output logic [7:0] dq_i
);
	import sfp_pkg::*;
	localparam logic [7:0] MAKER_CODE = 8'hc3; // Arbitrary value.
	localparam logic [7:0] PART_CODE = 8'h7e; // Arbitrary value.
	logic [7:0] mem [int];
	logic [7:0] page [128];
	logic [9:0] sect;
	logic [7:0] last_wr = 8'h00;
	logic [7:0] last_rd = 8'h00;
	logic [7:0] rdv;
	int nload = 0;
	logic [1:0] step = 2'h0;
	logic loading = 0;
	logic busy = 0;
	logic tog = 0;
	logic id_mode = 0;
	logic lk_lo = 0;
	logic lk_hi = 0;
	wire logic wstb = ce_n | we_n;
	wire logic rstb = ce_n | oe_n;
	// Writes latch as the earlier strobe rises; the program delay blocks here.
	always @(posedge wstb) begin
		if (oe_n && !busy) begin
			if (loading) begin
				page[addr[6:0]] = dq_o;
				sect = addr[16:7];
				last_wr = dq_o;
				nload++;
				if (nload == 128) begin
					loading = 0;
					busy = 1;
					#(PROG_NS);
					for (int i = 0; i < 128; i++) begin
						if (!(lk_lo && sect < 10'h040) &&
							!(lk_hi && sect > 10'h3bf)) begin
							mem[{sect, i[6:0]}] = page[i];
						end
					end
					busy = 0;
				end
			end else if (step == 2'h2 && addr[14:0] == KEY_ADDR1) begin
				step = 2'h0;
				case (dq_o)
				CMD_PROG: begin
					loading = 1;
					nload = 0;
					foreach (page[i]) page[i] = 8'hxx;
				end
				CMD_ID_ENTRY: id_mode = 1;
				CMD_ID_EXIT: id_mode = 0;
				CMD_LOCK_LO: lk_lo = 1;
				CMD_LOCK_HI: lk_hi = 1;
				default: step = 2'h0;
				endcase
			end else if (step == 2'h1 && addr[14:0] == KEY_ADDR2 &&
				dq_o == KEY_DAT2) begin
				step = 2'h2;
			end else begin
				step = (addr[14:0] == KEY_ADDR1 && dq_o == KEY_DAT1) ? 2'h1 : 2'h0;
			end
		end
	end
	// Each read strobe while programming flips the toggle bit.
	always @(negedge rstb) begin
		if (busy) begin
			tog = ~tog;
		end
	end
	// Read value: status while busy, codes in identification mode.
	always @* begin
		if (busy) begin
			rdv = {~last_wr[7], tog, 6'h00};
		end else if (id_mode && addr[16:1] == 16'h0000) begin
			rdv = addr[0] ? PART_CODE : MAKER_CODE;
		end else begin
			rdv = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
		end
	end
	// A released bus shows the inverse of the last value, never a stale copy.
	always @(posedge rstb) begin
		last_rd = rdv;
	end
	assign dq_i = (!rstb && we_n) ? rdv : (!dq_oe_n ? dq_o : ~last_rd);
endmodule // sfp_flash_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the sector flash host controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sfp_pkg::*;
	localparam int PROG_NS = 5000;
	logic sys_clk = 0;
	logic rst = 1;
	logic cmd_valid = 0;
	logic wr_valid = 0;
	sfp_op_e cmd_op = SFP_OP_READ;
	logic [16:0] cmd_addr = 17'h00000;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_ready, done, err, busy, ce_n, oe_n, we_n, dq_oe_n;
	logic [7:0] rd_data, dq_i, dq_o;
	logic [16:0] f_addr;
	int error_cnt = 0;
	int total_checks = 0;
	sfp_host #(.LOAD_WIN(200), .PROG_TMO(2000)) dut (.sys_clk(sys_clk),
		.rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_data(rd_data),
		.done(done), .err(err), .busy(busy), .flash_addr(f_addr),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n));
	sfp_flash_model #(.PROG_NS(PROG_NS)) fm (.addr(f_addr), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
		.dq_i(dq_i));
	// Clock at 125 MHz.
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input logic [16:0] exp, input logic [16:0] got,
		input string nm);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Presents one command; it is taken at the next edge while idle.
	task automatic issue(input sfp_op_e op, input logic [16:0] a);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		@(posedge sys_clk);
		chk(1'b1, cmd_ready, "cmd_ready at take");
		cmd_valid <= 1'b0;
		// One cycle after the take the controller must report busy.
		@(posedge sys_clk);
		chk(1'b1, busy, "busy after take");
		chk(1'b0, cmd_ready, "cmd_ready while busy");
	endtask
	// Waits for the done pulse and returns the cycles spent.
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (done !== 1'b1 && n < 20000);
		chk(1'b1, done, "done");
		chk(1'b0, busy, "busy after done");
	endtask
	// Runs a command that must end without error.
	task automatic run(input sfp_op_e op, input logic [16:0] a);
		int n;
		issue(op, a);
		wait_done(n);
		chk(1'b0, err, "err");
	endtask
	// Reads one location and compares the byte.
	task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp,
		input string nm);
		run(SFP_OP_READ, a);
		chk(exp, rd_data, nm);
	endtask
	// Programs a whole sector, then reads its end bytes back.
	task automatic t_prog(input logic [9:0] s);
		int n;
		issue(SFP_OP_PROG, {s, 7'h00});
		wr_valid <= 1'b1;
		for (int i = 0; i < 128; i++) begin
			wr_data <= 8'(i) ^ s[7:0];
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (wr_ready !== 1'b1 && n < 200);
			chk(1'b1, wr_ready, "byte taken");
		end
		wr_valid <= 1'b0;
		wait_done(n);
		chk(1'b0, err, "prog err");
		chk(1'b1, n > PROG_NS / CLK_NS, "poll span");
		rd_chk({s, 7'h00}, s[7:0], "first byte");
		rd_chk({s, 7'h7f}, 8'h7f ^ s[7:0], "last byte");
		$display("test prog sector %h finished", s);
	endtask
	// Identification codes, then normal reads after the exit sequence.
	task automatic t_ident;
		run(SFP_OP_ID_ENTRY, 17'h00000);
		rd_chk(17'h00000, fm.MAKER_CODE, "maker");
		rd_chk(17'h00001, fm.PART_CODE, "part");
		run(SFP_OP_ID_EXIT, 17'h00000);
		rd_chk(17'h002ff, 8'h7a, "array after exit");
		$display("test ident finished");
	endtask
	// Both lockout variants reach the flash.
	task automatic t_lock;
		run(SFP_OP_LOCK_LO, 17'h00000);
		chk(2'h2, {fm.lk_lo, fm.lk_hi}, "lock low");
		run(SFP_OP_LOCK_HI, 17'h00000);
		chk(2'h3, {fm.lk_lo, fm.lk_hi}, "lock both");
		$display("test lock finished");
	endtask
	// A program with no bytes must abort with an error.
	task automatic t_gap;
		int n;
		issue(SFP_OP_PROG, 17'h00100);
		wait_done(n);
		chk(1'b1, err, "gap err");
		$display("test gap finished");
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd_chk(17'h00000, 8'hff, "power-up read");
		t_prog(10'h005);
		t_prog(10'h3fe);
		t_ident;
		t_lock;
		t_gap;
		end_sim;
	end
	// Watchdog against a hang.
	initial begin
		repeat (40000) @(posedge sys_clk);
		error_cnt++;
		end_sim;
	end
endmodule // testbench
`default_nettype wire
